// File: src/slave_prm_cfg_diag_handshake.sv
/*
 * Parameter, configuration and diagnosis buffer handshake with an
 * AHB-Lite register slave.
 * Assumes one AHB-Lite master, zero wait states, and a telegram engine
 * that reports at most one received telegram per cycle.
 */
`timescale 1ns/1ps
`include "handshake_map.svh"

// Function
// - good long prm telegram swaps, records length, interrupts
// - whole prm telegram kept in buffer
// - only accept/reject reads clear prm/cfg interrupts
// - prm reject sets diag bits, goes wait-prm
// - prm cells return 00/01/11, upper bits zero
// - finished, conflict, not-allowed meanings
// - second prm telegram gives conflict, fresh buffer
// - good cfg telegram swaps, records length, interrupts
// - cfg reject changes diag bits, goes wait-prm
// - cfg accept in wait-cfg enters exchange when counters zero
// - entering exchange raises entry/exit interrupt
// - second cfg telegram gives conflict, fresh buffer
// - cfg cells return 00/01/11, upper bits zero
// - two diag buffers, one device-owned always
// - new-diag command when not diag_busy swaps buffers, raises interrupt
// - swap sets diag flag, flag asks priority
// - master fetch clears flag unless static
// - diag flag readable in status register
// - new-diag read at 0D returns owned buffer, no buffer when diag_busy
module slave_prm_cfg_diag_handshake #(
    parameter int ADDR_W = 8,
    parameter int LEN_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic prm_rx_ok,
    input wire logic [LEN_W-1:0] prm_rx_len,
    input wire logic cfg_rx_ok,
    input wire logic [LEN_W-1:0] cfg_rx_len,
    input wire logic diag_busy,
    input wire logic diag_fetched,
    input wire logic stat_diag,
    output logic [1:0] prm_buf,
    output logic [1:0] cfg_buf,
    output logic [1:0] aux_buf,
    output logic diag_dev_buf,
    output logic hi_prio_resp,
    output logic [1:0] slave_state_machine,
    output logic [3:0] irq_req
);

    if (ADDR_W < 8 || LEN_W != 8) begin : g_bad_param
        $error("unsupported ADDR_W or LEN_W");
    end

    ////////////////////////////////////////////////////////////////////
    // state
    handshake_pkg::slave_state_t state_r, state_nxt;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic [1:0] prm_buf_r, cfg_buf_r, aux_buf_r;
    logic diag_dev_r;
    logic diag_flag_r;
    logic [3:0] irq_r;
    logic [1:0] prm_cnt_r, prm_cnt_nxt, cfg_cnt_r, cfg_cnt_nxt;
    logic [LEN_W-1:0] prm_len_r, cfg_len_r;
    logic prm_fault_r, cfg_fault_r;
    logic wr_pend_r;

    ////////////////////////////////////////////////////////////////////
    // bus decode
    logic acc, rd;
    logic [5:0] idx;
    logic prm_rd, cfg_rd, prm_ok_rd, prm_nok_rd, cfg_ok_rd, cfg_nok_rd;
    logic diag_rd;

    assign acc = hsel && htrans[1] && hready;
    assign rd = acc && !hwrite;
    assign idx = haddr[7:2];
    // one access is one address phase, so one side effect
    assign prm_ok_rd = rd && idx == `IDX_PRM_OK;
    assign prm_nok_rd = rd && idx == `IDX_PRM_NOK;
    assign cfg_ok_rd = rd && idx == `IDX_CFG_OK;
    assign cfg_nok_rd = rd && idx == `IDX_CFG_NOK;
    assign prm_rd = prm_ok_rd || prm_nok_rd;
    assign cfg_rd = cfg_ok_rd || cfg_nok_rd;
    assign diag_rd = rd && idx == `IDX_NEW_DIAG;

    function automatic logic [1:0] ack_code(input logic allowed,
                                            input logic [1:0] left);
        if (!allowed)
            ack_code = `ACK_NOT_ALLOWED;
        else if (left != 2'h0)
            ack_code = `ACK_CONFLICT;
        else
            ack_code = `ACK_FINISHED;
    endfunction : ack_code

    function automatic logic [1:0] owner(input logic dev);
        if (!dev)
            owner = `OWN_USER;
        else if (diag_busy)
            owner = `OWN_SEND;
        else
            owner = `OWN_DEV;
    endfunction : owner

    ////////////////////////////////////////////////////////////////////
    // pending counters
    logic prm_inc, cfg_inc, prm_dec, cfg_dec, diag_swap;

    assign prm_inc = prm_rx_ok && prm_rx_len > `PRM_MIN_LEN;
    assign cfg_inc = cfg_rx_ok && !prm_rx_ok;
    assign prm_dec = prm_rd && prm_cnt_r != 2'h0;
    assign cfg_dec = cfg_rd && cfg_cnt_r != 2'h0;
    assign diag_swap = diag_rd && !diag_busy;

    always_comb begin
        prm_cnt_nxt = prm_cnt_r;
        if (prm_inc && !prm_dec && prm_cnt_r != 2'h3)
            prm_cnt_nxt = prm_cnt_r + 2'h1;
        else if (!prm_inc && prm_dec)
            prm_cnt_nxt = prm_cnt_r - 2'h1;
        cfg_cnt_nxt = cfg_cnt_r;
        if (cfg_inc && !cfg_dec && cfg_cnt_r != 2'h3)
            cfg_cnt_nxt = cfg_cnt_r + 2'h1;
        else if (!cfg_inc && cfg_dec)
            cfg_cnt_nxt = cfg_cnt_r - 2'h1;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prm_cnt_r <= 2'h0;
            cfg_cnt_r <= 2'h0;
        end else begin
            prm_cnt_r <= prm_cnt_nxt;
            cfg_cnt_r <= cfg_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer swaps and lengths
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prm_buf_r <= `RST_PRM_BUF;
            cfg_buf_r <= `RST_CFG_BUF;
            aux_buf_r <= `RST_AUX_BUF;
            prm_len_r <= '0;
            cfg_len_r <= '0;
        end else if (prm_inc) begin
            // whole telegram lands in the fresh buffer
            prm_buf_r <= aux_buf_r;
            aux_buf_r <= prm_buf_r;
            prm_len_r <= prm_rx_len;
        end else if (cfg_inc) begin
            cfg_buf_r <= aux_buf_r;
            aux_buf_r <= cfg_buf_r;
            cfg_len_r <= cfg_rx_len;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // slave state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            handshake_pkg::ST_WAIT_PRM: begin
                if (prm_ok_rd && prm_dec && prm_cnt_nxt == 2'h0)
                    state_nxt = handshake_pkg::ST_WAIT_CFG;
            end
            handshake_pkg::ST_WAIT_CFG: begin
                if (cfg_ok_rd && cfg_dec && prm_cnt_nxt == 2'h0
                    && cfg_cnt_nxt == 2'h0)
                    state_nxt = handshake_pkg::ST_CYCLIC_EXCHANGE;
            end
            handshake_pkg::ST_CYCLIC_EXCHANGE: begin
                if (prm_inc)
                    state_nxt = handshake_pkg::ST_WAIT_PRM;
            end
            default: state_nxt = handshake_pkg::ST_WAIT_PRM;
        endcase
        if ((prm_nok_rd && prm_dec) || (cfg_nok_rd && cfg_dec))
            state_nxt = handshake_pkg::ST_WAIT_PRM;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            state_r <= handshake_pkg::ST_WAIT_PRM;
        else
            state_r <= state_nxt;
    end

    // diagnosis fault bits
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prm_fault_r <= 1'b0;
            cfg_fault_r <= 1'b0;
        end else begin
            if (prm_nok_rd && prm_dec)
                prm_fault_r <= 1'b1;
            else if (prm_ok_rd && prm_dec)
                prm_fault_r <= 1'b0;
            if (cfg_nok_rd && cfg_dec)
                cfg_fault_r <= 1'b1;
            else if (cfg_ok_rd && cfg_dec)
                cfg_fault_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events: set wins over every clear
    logic exch_edge;
    logic [3:0] ack_clr;

    assign exch_edge = (state_nxt == handshake_pkg::ST_CYCLIC_EXCHANGE)
                       != (state_r == handshake_pkg::ST_CYCLIC_EXCHANGE);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            wr_pend_r <= 1'b0;
        else
            wr_pend_r <= acc && hwrite && idx == `IDX_IRQ_ACK;
    end

    // the ack register never reaches the prm and cfg bits
    assign ack_clr = wr_pend_r ? {hwdata[3:2], 2'h0} : 4'h0;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_r <= 4'h0;
        end else begin
            if (prm_inc)
                irq_r[`EV_NEW_PRM] <= 1'b1;
            else if (prm_dec && prm_cnt_nxt == 2'h0)
                irq_r[`EV_NEW_PRM] <= 1'b0;
            if (cfg_inc)
                irq_r[`EV_NEW_CFG] <= 1'b1;
            else if (cfg_dec && cfg_cnt_nxt == 2'h0)
                irq_r[`EV_NEW_CFG] <= 1'b0;
            if (diag_swap)
                irq_r[`EV_DIAG_CHG] <= 1'b1;
            else if (ack_clr[`EV_DIAG_CHG])
                irq_r[`EV_DIAG_CHG] <= 1'b0;
            if (exch_edge)
                irq_r[`EV_EXCH] <= 1'b1;
            else if (ack_clr[`EV_EXCH])
                irq_r[`EV_EXCH] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // diagnosis buffers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            diag_dev_r <= 1'b0;
            diag_flag_r <= 1'b0;
        end else begin
            if (diag_swap)
                diag_dev_r <= !diag_dev_r;
            if (diag_swap)
                diag_flag_r <= 1'b1;
            else if (diag_fetched && !stat_diag)
                diag_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx)
            `IDX_DIAG_SM:
                rd_val[3:0] = {owner(diag_dev_r), owner(!diag_dev_r)};
            `IDX_NEW_DIAG: begin
                if (diag_swap)
                    rd_val[1:0] = diag_dev_r ? `DIAG_BUF2
                                             : `DIAG_BUF1;
                else
                    rd_val[1:0] = `DIAG_NO_BUF;
            end
            `IDX_PRM_OK, `IDX_PRM_NOK:
                rd_val[1:0] = ack_code(prm_cnt_r != 2'h0,
                                       prm_cnt_nxt);
            `IDX_CFG_OK, `IDX_CFG_NOK:
                rd_val[1:0] = ack_code(cfg_cnt_r != 2'h0,
                                       cfg_cnt_nxt);
            `IDX_STATUS:
                rd_val[5:0] = {cfg_fault_r, prm_fault_r, state_r,
                               diag_dev_r, diag_flag_r};
            `IDX_IRQ_REQ: rd_val[3:0] = irq_r;
            `IDX_LEN_PRM: rd_val[LEN_W-1:0] = prm_len_r;
            `IDX_LEN_CFG: rd_val[LEN_W-1:0] = cfg_len_r;
            `IDX_BUF_SEL: rd_val[5:0] = {aux_buf_r, cfg_buf_r, prm_buf_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            if (rd)
                hrdata_r <= rd_val;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign prm_buf = prm_buf_r;
    assign cfg_buf = cfg_buf_r;
    assign aux_buf = aux_buf_r;
    assign diag_dev_buf = diag_dev_r;
    assign hi_prio_resp = diag_flag_r;
    assign slave_state_machine = state_r;
    assign irq_req = irq_r;

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_prm_swap;
        logic [1:0] a;
        (prm_inc, a = aux_buf_r) |=> prm_buf_r == a
            && irq_r[`EV_NEW_PRM] && prm_len_r == $past(prm_rx_len);
    endproperty
    a_prm_swap: assert property (p_prm_swap)
        else $error("prm swap missing");

    property p_ack_no_prm;
        wr_pend_r && !prm_rd && !prm_inc |=>
            irq_r[`EV_NEW_PRM] == $past(irq_r[`EV_NEW_PRM]);
    endproperty
    a_ack_no_prm: assert property (p_ack_no_prm)
        else $error("ack write touched prm event");

    property p_prm_rej;
        prm_nok_rd && prm_dec |=> state_r == handshake_pkg::ST_WAIT_PRM
            && prm_fault_r;
    endproperty
    a_prm_rej: assert property (p_prm_rej)
        else $error("prm reject wrong");

    property p_prm_code;
        prm_rd ##1 1'b1 |-> hrdata[31:2] == 30'h0
            && hrdata[1:0] != 2'h2;
    endproperty
    a_prm_code: assert property (p_prm_code)
        else $error("prm cell code bad");

    property p_conflict;
        prm_rd && prm_cnt_r == 2'h2 && !prm_inc |=>
            hrdata[1:0] == `ACK_CONFLICT ##0 irq_r[`EV_NEW_PRM];
    endproperty
    a_conflict: assert property (p_conflict)
        else $error("conflict not reported");

    property p_not_allowed;
        cfg_rd && cfg_cnt_r == 2'h0 |=> hrdata[1:0] == `ACK_NOT_ALLOWED;
    endproperty
    a_not_allowed: assert property (p_not_allowed)
        else $error("not allowed missing");

    property p_cfg_swap;
        cfg_inc |=> cfg_buf_r == $past(aux_buf_r) && irq_r[`EV_NEW_CFG];
    endproperty
    a_cfg_swap: assert property (p_cfg_swap)
        else $error("cfg swap missing");

    property p_enter_exch;
        state_r == handshake_pkg::ST_WAIT_CFG && cfg_ok_rd
            && cfg_cnt_r == 2'h1 && prm_cnt_r == 2'h0
            && !cfg_inc && !prm_inc |=>
            state_r == handshake_pkg::ST_CYCLIC_EXCHANGE
            && irq_r[`EV_EXCH];
    endproperty
    a_enter_exch: assert property (p_enter_exch)
        else $error("exchange not entered");

    property p_diag_flag;
        diag_swap |=> diag_flag_r && irq_r[`EV_DIAG_CHG]
            && diag_dev_r != $past(diag_dev_r);
    endproperty
    a_diag_flag: assert property (p_diag_flag)
        else $error("diag swap wrong");

    property p_diag_clr;
        diag_fetched && !stat_diag && !diag_swap |=> !diag_flag_r;
    endproperty
    a_diag_clr: assert property (p_diag_clr)
        else $error("diag flag not cleared");

    c_prm_accept: cover property (prm_ok_rd && prm_dec);
    c_conflict: cover property (prm_rd && prm_cnt_r == 2'h2);
    c_exch: cover property (state_r == handshake_pkg::ST_CYCLIC_EXCHANGE);
    c_diag: cover property (diag_swap ##[1:20] diag_fetched);

endmodule : slave_prm_cfg_diag_handshake

// File: src/handshake_map.svh
/*
 * Register indices, field codes and reset values of the parameter,
 * configuration and diagnosis handshake block.
 * Assumes byte address = 4 * index on a 32-bit AHB-Lite bus.
 */
`ifndef HANDSHAKE_MAP_SVH
`define HANDSHAKE_MAP_SVH

// register indices (byte address is four times these)
`define IDX_DIAG_SM 6'h0C
`define IDX_NEW_DIAG 6'h0D
`define IDX_PRM_OK 6'h0E
`define IDX_PRM_NOK 6'h0F
`define IDX_CFG_OK 6'h10
`define IDX_CFG_NOK 6'h11
`define IDX_STATUS 6'h20
`define IDX_IRQ_REQ 6'h21
`define IDX_IRQ_ACK 6'h22
`define IDX_LEN_PRM 6'h23
`define IDX_LEN_CFG 6'h24
`define IDX_BUF_SEL 6'h25

// answer codes of the command cells
`define ACK_FINISHED 2'h0
`define ACK_CONFLICT 2'h1
`define ACK_NOT_ALLOWED 2'h3

// diagnosis buffer codes
`define DIAG_NO_BUF 2'h0
`define DIAG_BUF1 2'h1
`define DIAG_BUF2 2'h2
`define OWN_USER 2'h1
`define OWN_DEV 2'h2
`define OWN_SEND 2'h3

// event bit positions
`define EV_NEW_PRM 0
`define EV_NEW_CFG 1
`define EV_DIAG_CHG 2
`define EV_EXCH 3

// longest parameter telegram that is not handed to the host
`define PRM_MIN_LEN 8'h07

// reset buffer assignment
`define RST_PRM_BUF 2'h0
`define RST_CFG_BUF 2'h1
`define RST_AUX_BUF 2'h2

`endif

// File: src/handshake_pkg.sv
/*
 * Types of the handshake block.
 * Assumes nothing of its surroundings.
 */
package handshake_pkg;
    typedef enum logic [1:0] {
        ST_WAIT_PRM,
        ST_WAIT_CFG,
        ST_CYCLIC_EXCHANGE
    } slave_state_t;
endpackage : handshake_pkg

// File: testbench/host_model.sv
/*
 * Host model: an AHB-Lite master plus the host answer sequences.
 * Assumes hready is the one slave's hreadyout and callers sit at an edge.
 */
`timescale 1ns/1ps
`include "handshake_map.svh"
module host_model (
    input wire logic clk_sys,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50)
                testbench.give_up();
            @(posedge clk_sys);
        end
    endtask : wait_rdy
    // one single word transfer, address phase then data phase
    task automatic xfer(input logic [5:0] idx, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic rd(input logic [5:0] idx, output logic [31:0] d);
        xfer(idx, 1'b0, ~hwdata, d);
    endtask : rd
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] junk;
        xfer(idx, 1'b1, d, junk);
    endtask : wr
    ////////////////////////////////////////////////////////////////////////
    // exactly one accept or reject read per new event
    task automatic answer(input bit cfg, input bit ok,
                          output logic [31:0] d);
        if (cfg)
            rd(ok ? `IDX_CFG_OK : `IDX_CFG_NOK, d);
        else
            rd(ok ? `IDX_PRM_OK : `IDX_PRM_NOK, d);
    endtask : answer
    // publish prepared diagnosis
    task automatic new_diag(output logic [31:0] d);
        rd(`IDX_NEW_DIAG, d);
    endtask : new_diag
endmodule : host_model

// File: testbench/testbench.sv
/*
 * Self-checking bench: random telegram lengths and conflict depths
 * with fixed corner cases.
 * Assumes host_model drives the register bus of the handshake block.
 */
`timescale 1ns/1ps
`include "handshake_map.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
    logic clk_sys, reset, hsel, hwrite, hreadyout, hresp;
    logic [7:0] haddr, prm_rx_len, cfg_rx_len, len;
    logic [1:0] htrans, prm_buf, cfg_buf, aux_buf, slave_state_machine;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d;
    logic prm_rx_ok, cfg_rx_ok, diag_busy, diag_fetched, stat_diag;
    logic diag_dev_buf, hi_prio_resp, ed;
    logic [3:0] irq_req;
    logic [1:0] ep, ec, ea, ow;
    int err_count, tests_run, pcnt, ccnt, k, n;

    slave_prm_cfg_diag_handshake slave_prm_cfg_diag_handshake_i (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .prm_rx_ok(prm_rx_ok),
        .prm_rx_len(prm_rx_len), .cfg_rx_ok(cfg_rx_ok),
        .cfg_rx_len(cfg_rx_len), .diag_busy(diag_busy),
        .diag_fetched(diag_fetched), .stat_diag(stat_diag),
        .prm_buf(prm_buf), .cfg_buf(cfg_buf), .aux_buf(aux_buf),
        .diag_dev_buf(diag_dev_buf), .hi_prio_resp(hi_prio_resp),
        .slave_state_machine(slave_state_machine), .irq_req(irq_req));
    host_model host_model_i (
        .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got %h expected %h", $time, g, e);
        end
    endtask : check_val
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic give_up;
        err_count++;
        summarize();
    endtask : give_up
    function automatic logic [1:0] ack_code(input int c);
        if (c == 0)
            return `ACK_NOT_ALLOWED;
        return (c > 1) ? `ACK_CONFLICT : `ACK_FINISHED;
    endfunction : ack_code
    ////////////////////////////////////////////////////////////////////////
    // one telegram pulse; expected buffer ids and counters follow it
    task automatic tel(input bit cfg, input logic [7:0] l);
        @(posedge clk_sys);
        prm_rx_ok <= !cfg;
        cfg_rx_ok <= cfg;
        prm_rx_len <= l;
        cfg_rx_len <= l;
        @(posedge clk_sys);
        prm_rx_ok <= 1'b0;
        cfg_rx_ok <= 1'b0;
        #1;
        if (cfg) begin
            {ec, ea} = {ea, ec};
            ccnt = (ccnt < 3) ? ccnt + 1 : 3;
        end else if (l > `PRM_MIN_LEN) begin
            {ep, ea} = {ea, ep};
            pcnt = (pcnt < 3) ? pcnt + 1 : 3;
        end
        `CHK({prm_buf, cfg_buf, aux_buf}, {ep, ec, ea});
    endtask : tel
    // one answer read, compared with the pending count
    task automatic ans(input bit cfg, input bit ok);
        host_model_i.answer(cfg, ok, d);
        n = cfg ? ccnt : pcnt;
        `CHK(d, ack_code(n));
        n = (n > 0) ? n - 1 : 0;
        if (cfg)
            ccnt = n;
        else
            pcnt = n;
        #1;
        `CHK(irq_req[cfg], n > 0);
    endtask : ans
    task automatic fetch(input logic s);
        @(posedge clk_sys);
        stat_diag <= s;
        diag_fetched <= 1'b1;
        @(posedge clk_sys);
        diag_fetched <= 1'b0;
        #1;
        `CHK(hi_prio_resp, s);
    endtask : fetch
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        give_up();
    end
    initial begin
        {reset, prm_rx_ok, cfg_rx_ok, diag_busy} = 4'hF;
        {prm_rx_ok, cfg_rx_ok, diag_busy, diag_fetched, stat_diag} = 5'h00;
        {prm_rx_len, cfg_rx_len} = 16'h0000;
        {ep, ec, ea, ed} = {`RST_PRM_BUF, `RST_CFG_BUF, `RST_AUX_BUF, 1'b0};
        {err_count, tests_run, pcnt, ccnt} = 128'h0;
        void'($urandom(32'h8A200E74));
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK({prm_buf, cfg_buf, aux_buf}, {ep, ec, ea});
        `CHK({irq_req, hresp}, 5'h00);
        for (k = 0; k < 4; k++)
            ans(k[1], k[0]);
        tel(1'b0, 8'h07);
        len = 8'($urandom_range(255, 8));
        tel(1'b0, len);
        host_model_i.rd(`IDX_LEN_PRM, d);
        `CHK(d, {24'h0, len});
        host_model_i.wr(`IDX_IRQ_ACK, 32'h0000_000F);
        #1;
        `CHK(irq_req[1:0], 2'h1);
        tel(1'b0, 8'h08);
        ans(1'b0, 1'b1);
        ans(1'b0, 1'b1);
        `CHK(slave_state_machine, handshake_pkg::ST_WAIT_CFG);
        tel(1'b0, 8'($urandom_range(255, 8)));
        ans(1'b0, 1'b0);
        `CHK(slave_state_machine, handshake_pkg::ST_WAIT_PRM);
        host_model_i.rd(`IDX_STATUS, d);
        `CHK(d[5:4], 2'h1);
        for (k = 0; k < 4; k++) begin
            repeat ($urandom_range(3, 1)) tel(1'b0, 8'($urandom()));
            while (pcnt > 0)
                ans(1'b0, 1'b1);
        end
        tel(1'b0, 8'h0A);
        tel(1'b1, 8'($urandom()));
        len = 8'($urandom());
        tel(1'b1, len);
        ans(1'b0, 1'b1);
        ans(1'b1, 1'b1);
        `CHK(slave_state_machine, handshake_pkg::ST_WAIT_CFG);
        ans(1'b1, 1'b1); // read-back cfg unchanged, nothing to copy
        `CHK({slave_state_machine, irq_req[3]}, 3'h5);
        host_model_i.rd(`IDX_LEN_CFG, d);
        `CHK(d, {24'h0, len});
        tel(1'b1, 8'h02);
        ans(1'b1, 1'b0);
        `CHK(slave_state_machine, handshake_pkg::ST_WAIT_PRM);
        host_model_i.rd(`IDX_STATUS, d);
        `CHK(d[5:4], 2'h2);
        for (k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            diag_busy <= (k == 0);
            host_model_i.new_diag(d);
            #1;
            if (k > 0)
                ed = ~ed;
            ow = ed ? `DIAG_BUF1 : `DIAG_BUF2;
            `CHK(d, (k == 0) ? `DIAG_NO_BUF : ow);
            `CHK({diag_dev_buf, hi_prio_resp}, {ed, k > 0});
            `CHK(irq_req[2], k > 0);
            host_model_i.rd(`IDX_DIAG_SM, d);
            // device buffer shows send mode while the master reads it
            ow = (k == 0) ? `OWN_SEND : `OWN_DEV;
            `CHK(d, ed ? {ow, `OWN_USER} : {`OWN_USER, ow});
            host_model_i.rd(`IDX_STATUS, d);
            `CHK(d[0], k > 0);
            if (k == 1) begin
                fetch(1'b1);
                fetch(1'b0);
                host_model_i.rd(`IDX_STATUS, d);
                `CHK(d[0], 1'b0);
            end
        end
        host_model_i.rd(`IDX_BUF_SEL, d);
        `CHK(d, {ea, ec, ep});
        host_model_i.rd(`IDX_IRQ_REQ, d);
        `CHK(d, 32'h0000_000C);
        summarize();
    end
endmodule : testbench
